// *** iocfg_pkg.sv ***
// Constants and carrier types for the configuration register bank.
package iocfg_pkg;

  // ----------------------------------------------------------------------
  // Host port addresses and keys
  // ----------------------------------------------------------------------
  localparam logic [15:0] PORT_LO_ENABLE = 16'h0250;
  localparam logic [15:0] PORT_LO_INDEX = 16'h0251;
  localparam logic [15:0] PORT_LO_DATA = 16'h0252;
  localparam logic [15:0] PORT_HI_ENABLE = 16'h03f0;
  localparam logic [15:0] PORT_HI_DATA = 16'h03f1;
  localparam logic [7:0] KEY_LO_0 = 8'h88;
  localparam logic [7:0] KEY_LO_1 = 8'h89;
  localparam logic [7:0] KEY_HI_0 = 8'h86;
  localparam logic [7:0] KEY_HI_1 = 8'h87;
  localparam logic [7:0] EXIT_HI = 8'haa;

  // ----------------------------------------------------------------------
  // Register map: index, writable bits and reset value per register
  // ----------------------------------------------------------------------
  localparam int NUM_REGS = 8;
  localparam logic [7:0] IDX_PAR_MODE_PWR = 8'h00;
  localparam logic [7:0] IDX_DRIVE_SWAP = 8'h01;
  localparam logic [7:0] IDX_RSVD_TWO = 8'h02;
  localparam logic [7:0] IDX_PROTO_CLK = 8'h03;
  localparam logic [7:0] IDX_PORT_PWR = 8'h04;
  localparam logic [7:0] IDX_ECP_THR = 8'h05;
  localparam logic [7:0] IDX_FLOPPY_SEL = 8'h06;
  localparam logic [7:0] IDX_DRIVE_TYPE = 8'h07;
  localparam logic [0:7][7:0] REG_WMASK = '{8'h0d, 8'h80, 8'h00, 8'h23,
                                           8'hbb, 8'h0f, 8'h3a, 8'hff};
  localparam logic [0:7][7:0] REG_RESET = '{8'h00, 8'h00, 8'h00, 8'h30,
                                           8'h00, 8'h00, 8'h00, 8'h00};

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int B_LEGACY_PD = 0;
  localparam int B_PMODE_LO = 2;
  localparam int B_DRIVE_SWAP = 7;
  localparam int B_EPP_VER = 5;
  localparam int B_UART_A_MIDI = 1;
  localparam int B_UART_B_MIDI = 0;
  localparam int B_PAR_PD = 7;
  localparam int B_UA_PD = 5;
  localparam int B_UB_PD = 4;
  localparam int B_PAR_FLT = 3;
  localparam int B_UA_FLT = 1;
  localparam int B_UB_FLT = 0;
  localparam int B_FOUR_DRV = 5;
  localparam int B_PULLUP_DIS = 4;
  localparam int B_FDC_PD = 3;
  localparam int B_FDC_FLT = 1;
  localparam int B_DOR_MOTOR = 4;

  // UART clock dividers from the 24 MHz source.
  localparam logic [3:0] UART_DIV_STD = 4'hd;
  localparam logic [3:0] UART_DIV_MIDI = 4'hc;

  // Drive type field codes.
  localparam logic [1:0] TYPE_NORMAL = 2'h0;
  localparam logic [1:0] TYPE_1M2 = 2'h1;
  localparam logic [1:0] TYPE_1M44 = 2'h2;
  localparam logic [1:0] TYPE_720K = 2'h3;

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic par_pd;
    logic par_float;
    logic uart_a_pd;
    logic uart_a_float;
    logic uart_b_pd;
    logic uart_b_float;
    logic fdc_pd;
    logic fdc_float;
  } iocfg_pwr_t;

  typedef struct packed {
    logic motor_on_a_n;
    logic motor_on_b_n;
    logic drive_select_a_n;
    logic drive_select_b_n;
  } iocfg_drv_t;

endpackage

// *** iocfg_bank.sv ***
// Indexed configuration register bank with key-protected host access.
`timescale 1ns/10ps
// Operation
// - Host writes index port, then data port reaches the selected register.
// - Index port is write-only, at 251H or 3F0H per entry method.
// - Data port reads and writes the indexed register, at 252H or 3F1H.
// - Three-bit parallel mode code selects normal, floppy, EPP, ECP modes.
// - Register 0 bit 0 stops the clock for legacy power-down.
// - Register 1 bit 7 swaps floppy drives A and B.
// - Register 3 bit 5 picks EPP version, 1.7 at reset.
// - Register 3 bit 1 sets first UART divider, 13 or 12.
// - Register 3 bit 0 sets second UART divider, 13 or 12.
// - Register 4 bits 7,5,4 power down parallel, UART A, UART B.
// - Register 4 bits 3,1,0 float those outputs while powered down.
// - Register 5 low nibble holds ECP FIFO threshold, reset zero.
// - Register 6 bit 5 picks two-drive or four-drive encoding.
// - Four-drive mode encodes selected drive; both motors low if any motor.
// - Register 6 bit 4 disables floppy input pull-ups when set.
// - Register 6 bit 3 powers down floppy; bit 1 floats its outputs.
// - Register 7 holds two-bit type fields for drives D, C, B, A.
// - Normal type: reduced write current low means 250, high 500 Kb/s.
// - Three-mode: low 1.2 MB, high 1.44 MB, code 11 720 KB.
// - A non-key write leaves the mode; at 3F0H it must be AAH.
// - With the lock input set, all register reads and writes are blocked.
// - Registers reset only on the cold reset pin.
module iocfg_bank (
  // Clock and cold reset
  input wire logic CLK,
  input wire logic RST,
  // Host I/O cycle, strobes active low and synchronous
  input wire logic [15:0] IO_ADDR,
  input wire logic IO_WRITE_N,
  input wire logic IO_READ_N,
  input wire logic [7:0] IO_DATA_IN,
  output logic [7:0] IO_DATA_OUT,
  output logic IO_DATA_OE,
  // Settings held in registers outside this bank
  input wire logic [1:0] ENTRY_METHOD,
  input wire logic CONFIG_LOCK,
  input wire logic PARALLEL_MODE_BIT2,
  input wire logic THREE_MODE_DRIVE_ENABLE,
  // Floppy controller status
  input wire logic [7:0] DIGITAL_OUTPUT_REG,
  input wire logic DATA_RATE_HIGH,
  // Mode and power outputs
  output logic CONFIG_MODE_ACTIVE,
  output logic [2:0] PARALLEL_MODE,
  output logic EXTERNAL_FLOPPY_MODE,
  output logic EXTERNAL_DUAL_FLOPPY_MODE,
  output logic PARALLEL_EPP_EN,
  output logic PARALLEL_ECP_EN,
  output logic LEGACY_POWER_DOWN,
  output logic DRIVE_SWAP,
  output logic EPP_VERSION_SELECT,
  output logic [3:0] UART_A_DIVIDER,
  output logic [3:0] UART_B_DIVIDER,
  output iocfg_pkg::iocfg_pwr_t POWER_CTRL,
  output logic [3:0] ECP_FIFO_LEVEL,
  output logic FOUR_DRIVE_SELECT,
  output logic FLOPPY_PULLUP_DISABLE,
  // Floppy drive pins
  output iocfg_pkg::iocfg_drv_t DRIVE_PINS,
  output logic REDUCED_WRITE_CURRENT_N,
  output logic MEDIA_720K
);
  import iocfg_pkg::*;

  typedef enum {ST_IDLE, ST_KEY_SEEN, ST_EXTENDED} iocfg_state_t;

  iocfg_state_t state_q;
  logic [7:0] index_q;
  logic [0:7][7:0] regs_q;
  logic wr_prev_q;
  logic wr_pulse;
  logic at_hi;
  logic [7:0] key;
  logic hit_enable;
  logic hit_index;
  logic hit_data;
  logic reg_ok;
  logic [2:0] reg_sel;
  logic [1:0] drv_sel;
  logic [3:0] rwc_n_drv;
  logic [3:0] is_720k;

  // ----------------------------------------------------------------------
  // Host cycle decode
  // ----------------------------------------------------------------------

  // A write acts once, on the first cycle its strobe is seen low.
  assign wr_pulse = !IO_WRITE_N && wr_prev_q;
  assign at_hi = ENTRY_METHOD[1];
  // Entry key chosen by the method select.
  always_comb begin
    case (ENTRY_METHOD)
      2'h0: key = KEY_LO_0;
      2'h1: key = KEY_LO_1;
      2'h2: key = KEY_HI_0;
      default: key = KEY_HI_1;
    endcase
  end
  assign hit_enable = IO_ADDR == (at_hi ? PORT_HI_ENABLE : PORT_LO_ENABLE);
  assign hit_index = at_hi ? (IO_ADDR == PORT_HI_ENABLE)
                           : (IO_ADDR == PORT_LO_INDEX);
  assign hit_data = IO_ADDR == (at_hi ? PORT_HI_DATA : PORT_LO_DATA);
  assign reg_ok = state_q == ST_EXTENDED && !CONFIG_LOCK
                  && index_q < 8'(NUM_REGS);
  assign reg_sel = index_q[2:0];

  // Write strobe edge tracking.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wr_prev_q <= 1'b1;
    end else begin
      wr_prev_q <= IO_WRITE_N;
    end
  end

  // ----------------------------------------------------------------------
  // Extended mode entry and exit
  // ----------------------------------------------------------------------

  // At 3F0H the enable and index ports share one address, so once in
  // extended mode only the exit value leaves; other values are indexes.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_q <= ST_IDLE;
    end else if (wr_pulse) begin
      case (state_q)
        ST_IDLE: begin
          if (hit_enable && IO_DATA_IN == key) begin
            state_q <= at_hi ? ST_KEY_SEEN : ST_EXTENDED;
          end
        end
        ST_KEY_SEEN: begin
          if (hit_enable && IO_DATA_IN == key) begin
            state_q <= ST_EXTENDED;
          end else begin
            state_q <= ST_IDLE;
          end
        end
        ST_EXTENDED: begin
          if (at_hi && hit_enable && IO_DATA_IN == EXIT_HI) begin
            state_q <= ST_IDLE;
          end else if (!at_hi && hit_enable && IO_DATA_IN != key) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Index and register storage
  // ----------------------------------------------------------------------

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      index_q <= 8'h00;
    end else if (wr_pulse && hit_index && state_q == ST_EXTENDED
                 && !CONFIG_LOCK
                 && !(at_hi && IO_DATA_IN == EXIT_HI)) begin
      index_q <= IO_DATA_IN;
    end
  end

  // One register per index; only documented bits can ever be set.
  for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
    always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
        regs_q[g] <= REG_RESET[g] & REG_WMASK[g];
      end else if (wr_pulse && hit_data && reg_ok
                   && reg_sel == 3'(g)) begin
        regs_q[g] <= IO_DATA_IN & REG_WMASK[g];
      end
    end
  end

  // Read data follows the indexed register while the read strobe is low.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      IO_DATA_OUT <= 8'h00;
    end else if (!IO_READ_N && hit_data && reg_ok) begin
      IO_DATA_OUT <= regs_q[reg_sel];
    end
  end

  assign IO_DATA_OE = !IO_READ_N && hit_data && reg_ok;
  assign CONFIG_MODE_ACTIVE = state_q == ST_EXTENDED;

  // ----------------------------------------------------------------------
  // Function settings
  // ----------------------------------------------------------------------

  always_comb begin
    PARALLEL_MODE = {PARALLEL_MODE_BIT2,
                     regs_q[IDX_PAR_MODE_PWR][B_PMODE_LO +: 2]};
    EXTERNAL_FLOPPY_MODE = PARALLEL_MODE == 3'h1;
    EXTERNAL_DUAL_FLOPPY_MODE = PARALLEL_MODE == 3'h3;
    PARALLEL_EPP_EN = PARALLEL_MODE == 3'h5 || PARALLEL_MODE == 3'h7;
    PARALLEL_ECP_EN = PARALLEL_MODE == 3'h6 || PARALLEL_MODE == 3'h7;
  end

  assign LEGACY_POWER_DOWN = regs_q[IDX_PAR_MODE_PWR][B_LEGACY_PD];
  assign DRIVE_SWAP = regs_q[IDX_DRIVE_SWAP][B_DRIVE_SWAP];
  assign EPP_VERSION_SELECT = regs_q[IDX_PROTO_CLK][B_EPP_VER];
  assign UART_A_DIVIDER = regs_q[IDX_PROTO_CLK][B_UART_A_MIDI]
                          ? UART_DIV_MIDI : UART_DIV_STD;
  assign UART_B_DIVIDER = regs_q[IDX_PROTO_CLK][B_UART_B_MIDI]
                          ? UART_DIV_MIDI : UART_DIV_STD;

  // Float only applies while the same function is powered down.
  always_comb begin
    POWER_CTRL.par_pd = regs_q[IDX_PORT_PWR][B_PAR_PD];
    POWER_CTRL.uart_a_pd = regs_q[IDX_PORT_PWR][B_UA_PD];
    POWER_CTRL.uart_b_pd = regs_q[IDX_PORT_PWR][B_UB_PD];
    POWER_CTRL.par_float = POWER_CTRL.par_pd
                           && regs_q[IDX_PORT_PWR][B_PAR_FLT];
    POWER_CTRL.uart_a_float = POWER_CTRL.uart_a_pd
                              && regs_q[IDX_PORT_PWR][B_UA_FLT];
    POWER_CTRL.uart_b_float = POWER_CTRL.uart_b_pd
                              && regs_q[IDX_PORT_PWR][B_UB_FLT];
    POWER_CTRL.fdc_pd = regs_q[IDX_FLOPPY_SEL][B_FDC_PD];
    POWER_CTRL.fdc_float = POWER_CTRL.fdc_pd
                           && regs_q[IDX_FLOPPY_SEL][B_FDC_FLT];
  end

  assign ECP_FIFO_LEVEL = regs_q[IDX_ECP_THR][3:0];
  assign FOUR_DRIVE_SELECT = regs_q[IDX_FLOPPY_SEL][B_FOUR_DRV];
  assign FLOPPY_PULLUP_DISABLE = regs_q[IDX_FLOPPY_SEL][B_PULLUP_DIS];

  // ----------------------------------------------------------------------
  // Drive pins
  // ----------------------------------------------------------------------

  assign drv_sel = DIGITAL_OUTPUT_REG[1:0];

  // Pins are registered so the drive cable sees no decode glitches.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      DRIVE_PINS <= '1;
    end else if (FOUR_DRIVE_SELECT) begin
      if (|DIGITAL_OUTPUT_REG[7:4]) begin
        // Select A carries code bit 0 and select B code bit 1.
        DRIVE_PINS <= {2'b00, drv_sel[0], drv_sel[1]};
      end else begin
        DRIVE_PINS <= '1;
      end
    end else begin
      DRIVE_PINS.motor_on_a_n <= !(DIGITAL_OUTPUT_REG[B_DOR_MOTOR]
                                   && drv_sel == 2'h0);
      DRIVE_PINS.drive_select_a_n <= !(DIGITAL_OUTPUT_REG[B_DOR_MOTOR]
                                       && drv_sel == 2'h0);
      DRIVE_PINS.motor_on_b_n <= !(DIGITAL_OUTPUT_REG[B_DOR_MOTOR + 1]
                                   && drv_sel == 2'h1);
      DRIVE_PINS.drive_select_b_n <= !(DIGITAL_OUTPUT_REG[B_DOR_MOTOR + 1]
                                       && drv_sel == 2'h1);
    end
  end

  for (genvar d = 0; d < 4; d++) begin : g_type
    logic [1:0] fld;
    assign fld = regs_q[IDX_DRIVE_TYPE][2*d +: 2];
    always_comb begin
      is_720k[d] = 1'b0;
      if (!THREE_MODE_DRIVE_ENABLE || fld == TYPE_NORMAL) begin
        rwc_n_drv[d] = DATA_RATE_HIGH;
      end else begin
        case (fld)
          TYPE_1M2: rwc_n_drv[d] = 1'b0;
          TYPE_1M44: rwc_n_drv[d] = 1'b1;
          default: begin
            rwc_n_drv[d] = 1'b1;
            is_720k[d] = 1'b1;
          end
        endcase
      end
    end
  end

  // The selected drive's field steers the write current pin.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      REDUCED_WRITE_CURRENT_N <= 1'b0;
      MEDIA_720K <= 1'b0;
    end else begin
      REDUCED_WRITE_CURRENT_N <= rwc_n_drv[drv_sel];
      MEDIA_720K <= is_720k[drv_sel];
    end
  end

endmodule

// *** iocfg_bank_monitor.sv ***
// Checker on the configuration bank ports, bound to the bank.
`timescale 1ns/10ps
module iocfg_bank_monitor (
  // Clock, reset and host strobes
  input wire logic CLK,
  input wire logic RST,
  input wire logic IO_WRITE_N,
  input wire logic IO_READ_N,
  input wire logic IO_DATA_OE,
  // Setting inputs
  input wire logic CONFIG_LOCK,
  input wire logic PARALLEL_MODE_BIT2,
  input wire logic [7:0] DIGITAL_OUTPUT_REG,
  // Settings from the bank
  input wire logic CONFIG_MODE_ACTIVE,
  input wire logic [2:0] PARALLEL_MODE,
  input wire logic PARALLEL_EPP_EN,
  input wire logic PARALLEL_ECP_EN,
  input wire logic LEGACY_POWER_DOWN,
  input wire logic DRIVE_SWAP,
  input wire logic [3:0] UART_A_DIVIDER,
  input wire iocfg_pkg::iocfg_pwr_t POWER_CTRL,
  input wire logic [3:0] ECP_FIFO_LEVEL,
  input wire logic FOUR_DRIVE_SELECT,
  input wire iocfg_pkg::iocfg_drv_t DRIVE_PINS
);
  import iocfg_pkg::*;
  // Settings that only a taken data write may change.
  wire logic [20:0] cfg = {LEGACY_POWER_DOWN, DRIVE_SWAP, UART_A_DIVIDER,
    POWER_CTRL, ECP_FIFO_LEVEL, FOUR_DRIVE_SELECT, PARALLEL_MODE[1:0]};
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  // Drive pin causes, sampled one edge before the registered pins.
  sequence s_two_sel;
    !FOUR_DRIVE_SELECT && DIGITAL_OUTPUT_REG[4] &&
      DIGITAL_OUTPUT_REG[1:0] == 2'h0;
  endsequence
  sequence s_four_on;
    FOUR_DRIVE_SELECT && DIGITAL_OUTPUT_REG[7:4] != 4'h0;
  endsequence
  property p_mode_decode;
    PARALLEL_MODE[2] == PARALLEL_MODE_BIT2 &&
      PARALLEL_EPP_EN == (PARALLEL_MODE inside {3'h5, 3'h7}) &&
      PARALLEL_ECP_EN == (PARALLEL_MODE inside {3'h6, 3'h7});
  endproperty
  a_mode_decode: assert property (p_mode_decode)
    else $error("parallel mode flags wrong");
  property p_two_sel;
    s_two_sel |=> DRIVE_PINS == 4'h5;
  endproperty
  a_two_sel: assert property (p_two_sel)
    else $error("two-drive select pins wrong");
  property p_two_idle;
    !FOUR_DRIVE_SELECT && DIGITAL_OUTPUT_REG[5:4] == 2'h0 |=>
      DRIVE_PINS == 4'hf;
  endproperty
  a_two_idle: assert property (p_two_idle)
    else $error("two-drive pins not idle");
  property p_four_on;
    s_four_on |=> DRIVE_PINS == {2'h0, $past(DIGITAL_OUTPUT_REG[0]),
      $past(DIGITAL_OUTPUT_REG[1])};
  endproperty
  a_four_on: assert property (p_four_on)
    else $error("four-drive encoding wrong");
  property p_four_off;
    FOUR_DRIVE_SELECT && DIGITAL_OUTPUT_REG[7:4] == 4'h0 |=>
      DRIVE_PINS == 4'hf;
  endproperty
  a_four_off: assert property (p_four_off)
    else $error("four-drive pins not idle");
  property p_oe;
    IO_DATA_OE |-> !IO_READ_N && CONFIG_MODE_ACTIVE && !CONFIG_LOCK;
  endproperty
  a_oe: assert property (p_oe)
    else $error("data driven without a valid read");
  property p_lock_hold;
    $past(CONFIG_LOCK) |-> $stable(cfg);
  endproperty
  a_lock_hold: assert property (p_lock_hold)
    else $error("setting changed under lock");
  property p_quiet;
    $past(IO_WRITE_N) |-> $stable(cfg) && $stable(CONFIG_MODE_ACTIVE);
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("state changed without a write");
endmodule
bind iocfg_bank iocfg_bank_monitor i_mon (.*);

// *** iocfg_host_model.sv ***
// Host model that issues I/O port cycles to the configuration bank.
`timescale 1ns/10ps
module iocfg_host_model (
  // Clock and read answer
  input wire logic CLK,
  input wire logic [7:0] IO_DATA_OUT,
  input wire logic IO_DATA_OE,
  // Host cycle
  output logic [15:0] IO_ADDR,
  output logic IO_WRITE_N,
  output logic IO_READ_N,
  output logic [7:0] IO_DATA_IN
);
  import iocfg_pkg::*;
  // Idle bus at time zero.
  initial begin
    IO_ADDR = 16'h0000;
    IO_WRITE_N = 1'b1;
    IO_READ_N = 1'b1;
    IO_DATA_IN = 8'h00;
  end
  // Write with one high cycle after it, so the next strobe is a new edge.
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge CLK);
    IO_ADDR <= a;
    IO_DATA_IN <= v;
    IO_WRITE_N <= 1'b0;
    @(posedge CLK);
    IO_WRITE_N <= 1'b1;
    IO_DATA_IN <= ~v;
  endtask
  // Read data is taken after the first edge that saw the strobe.
  task automatic rd(input logic [15:0] a, output logic [7:0] v,
                    output logic oe);
    @(posedge CLK);
    IO_ADDR <= a;
    IO_READ_N <= 1'b0;
    @(posedge CLK);
    @(posedge CLK);
    v = IO_DATA_OUT;
    oe = IO_DATA_OE;
    IO_READ_N <= 1'b1;
  endtask
  task automatic enter(input logic [1:0] m);
    if (m[1]) begin
      wr(PORT_HI_ENABLE, m[0] ? KEY_HI_1 : KEY_HI_0);
      wr(PORT_HI_ENABLE, m[0] ? KEY_HI_1 : KEY_HI_0);
    end else begin
      wr(PORT_LO_ENABLE, m[0] ? KEY_LO_1 : KEY_LO_0);
    end
  endtask
  task automatic leave(input logic [1:0] m);
    wr(m[1] ? PORT_HI_ENABLE : PORT_LO_ENABLE, m[1] ? EXIT_HI : 8'h00);
  endtask
  task automatic cfg_wr(input logic [1:0] m, input logic [7:0] i,
                        input logic [7:0] v);
    wr(m[1] ? PORT_HI_ENABLE : PORT_LO_INDEX, i);
    wr(m[1] ? PORT_HI_DATA : PORT_LO_DATA, v);
  endtask
  task automatic cfg_rd(input logic [1:0] m, input logic [7:0] i,
                        output logic [7:0] v, output logic oe);
    wr(m[1] ? PORT_HI_ENABLE : PORT_LO_INDEX, i);
    rd(m[1] ? PORT_HI_DATA : PORT_LO_DATA, v, oe);
  endtask
endmodule

// *** tb_top.sv ***
// Self-checking bench for the configuration register bank.
`timescale 1ns/10ps
module tb_top;
  import iocfg_pkg::*;
  logic clk = 1'b0, rst = 1'b1, lock = 1'b0, pm2 = 1'b0, three = 1'b0;
  logic rate = 1'b0, wr_n, rd_n, oe, cma, extf, ext2, epp, ecp, e;
  logic lpd, swap, eppv, four, pud, reduced_write_current_n, m720;
  logic [1:0] method = 2'h1;
  logic [2:0] pmode;
  logic [3:0] diva, divb, ecpl;
  logic [7:0] dor = 8'h00, din, dout, d, v, idx;
  logic [15:0] addr;
  iocfg_pwr_t pwr;
  iocfg_drv_t pins;
  int n_fail = 0, tests_run = 0;
  localparam logic [0:11][15:0] SETS = '{16'h0001, 16'h0180, 16'h0323,
    16'h043b, 16'h050a, 16'h063a, 16'h0000, 16'h0100, 16'h0300,
    16'h040b, 16'h050f, 16'h060a};
  iocfg_bank i_iocfg_bank (.CLK(clk), .RST(rst), .IO_ADDR(addr),
    .IO_WRITE_N(wr_n), .IO_READ_N(rd_n), .IO_DATA_IN(din),
    .IO_DATA_OUT(dout), .IO_DATA_OE(oe), .ENTRY_METHOD(method),
    .CONFIG_LOCK(lock), .PARALLEL_MODE_BIT2(pm2),
    .THREE_MODE_DRIVE_ENABLE(three), .DIGITAL_OUTPUT_REG(dor),
    .DATA_RATE_HIGH(rate), .CONFIG_MODE_ACTIVE(cma), .PARALLEL_MODE(pmode),
    .EXTERNAL_FLOPPY_MODE(extf), .EXTERNAL_DUAL_FLOPPY_MODE(ext2),
    .PARALLEL_EPP_EN(epp), .PARALLEL_ECP_EN(ecp), .LEGACY_POWER_DOWN(lpd),
    .DRIVE_SWAP(swap), .EPP_VERSION_SELECT(eppv), .UART_A_DIVIDER(diva),
    .UART_B_DIVIDER(divb), .POWER_CTRL(pwr), .ECP_FIFO_LEVEL(ecpl),
    .FOUR_DRIVE_SELECT(four), .FLOPPY_PULLUP_DISABLE(pud),
    .DRIVE_PINS(pins), .REDUCED_WRITE_CURRENT_N(reduced_write_current_n), .MEDIA_720K(m720));
  iocfg_host_model i_host (.CLK(clk), .IO_DATA_OUT(dout), .IO_DATA_OE(oe),
    .IO_ADDR(addr), .IO_WRITE_N(wr_n), .IO_READ_N(rd_n), .IO_DATA_IN(din));
  // Free-running 20 MHz clock.
  always #25 clk = ~clk;
  // Every compare is counted; a mismatch is reported at once.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Expected drive pins; the pins are active low.
  function automatic iocfg_drv_t pins_exp(input logic f, input logic [7:0] r);
    logic a, b;
    a = r[4] && r[1:0] == 2'h0;
    b = r[5] && r[1:0] == 2'h1;
    if (!f) return {~a, ~b, ~a, ~b};
    if (r[7:4] == 4'h0) return 4'hf;
    return {2'h0, r[0], r[1]};
  endfunction
  // Expected {720K flag, write current level} for one drive type field.
  function automatic logic [1:0] media_exp(input logic t, input logic r,
                                           input logic [1:0] f);
    if (!t || f == TYPE_NORMAL) return {1'b0, r};
    if (f == TYPE_1M2) return 2'h0;
    if (f == TYPE_1M44) return 2'h1;
    return 2'h3;
  endfunction
  // Main sequence.
  initial begin
    void'($urandom(74862));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    i_host.enter(2'h1);
    for (int i = 0; i < 9; i++) begin
      i_host.cfg_rd(2'h1, 8'(i), d, e);
      check(e, i < 8);
      if (i < 8) check(d, REG_RESET[i] & REG_WMASK[i]);
    end
    i_host.rd(PORT_LO_INDEX, d, e);
    check(e, 1'b0);
    check({eppv, diva, divb}, {1'b1, UART_DIV_STD, UART_DIV_STD});
    i_host.leave(2'h1);
    $display("reset test ended");
    // Each entry method; a write after exit must be refused.
    for (int m = 0; m < 4; m++) begin
      method <= 2'(m);
      @(posedge clk);
      i_host.enter(2'(m));
      i_host.cfg_rd(2'(m), IDX_ECP_THR, d, e);
      check(d, m == 0 ? 8'h00 : 8'(m + 3));
      i_host.cfg_wr(2'(m), IDX_ECP_THR, 8'(m + 4));
      i_host.leave(2'(m));
      i_host.cfg_wr(2'(m), IDX_ECP_THR, 8'h0c);
      @(posedge clk);
      check({cma, ecpl}, {1'b0, 4'(m + 4)});
    end
    $display("entry test ended");
    method <= 2'h1;
    @(posedge clk);
    i_host.enter(2'h1);
    for (int n = 0; n < 32; n++) begin
      idx = 8'($urandom_range(7));
      v = 8'($urandom);
      i_host.cfg_wr(2'h1, idx, v);
      i_host.cfg_rd(2'h1, idx, d, e);
      check(d, v & REG_WMASK[idx[2:0]]);
    end
    for (int i = 0; i < 12; i++) begin
      i_host.cfg_wr(2'h1, SETS[i][15:8], SETS[i][7:0]);
      if (i % 6 == 5) begin
        @(posedge clk);
        check({lpd, swap, eppv, diva, divb, pwr, ecpl, four, pud}, i < 6 ?
          {3'h7, UART_DIV_MIDI, UART_DIV_MIDI, 8'h3f, 4'ha, 2'h3} :
          {3'h0, UART_DIV_STD, UART_DIV_STD, 8'h03, 4'hf, 2'h0});
      end
    end
    for (int c = 0; c < 8; c++) begin
      pm2 <= c[2];
      i_host.cfg_wr(2'h1, IDX_PAR_MODE_PWR, {4'h0, 2'(c), 2'h0});
      @(posedge clk);
      check({pmode, extf, ext2, epp, ecp}, {3'(c), c == 1, c == 3,
        c == 5 || c == 7, c == 6 || c == 7});
    end
    $display("settings test ended");
    // A locked bank neither answers nor takes writes.
    lock <= 1'b1;
    i_host.cfg_wr(2'h1, IDX_ECP_THR, 8'h05);
    i_host.cfg_rd(2'h1, IDX_ECP_THR, d, e);
    check(e, 1'b0);
    lock <= 1'b0;
    i_host.cfg_rd(2'h1, IDX_ECP_THR, d, e);
    check(d, 8'h0f);
    $display("lock test ended");
    for (int n = 0; n < 48; n++) begin
      if (n % 24 == 0) begin
        i_host.cfg_wr(2'h1, IDX_FLOPPY_SEL, n > 0 ? 8'h20 : 8'h00);
        idx = n > 0 ? 8'($urandom) : 8'he4;
        i_host.cfg_wr(2'h1, IDX_DRIVE_TYPE, idx);
      end
      v = n % 24 < 4 ? 8'((8'h10 << (n % 4)) | (n % 4)) : 8'($urandom);
      dor <= v;
      three <= v[2];
      rate <= v[3];
      @(posedge clk);
      @(posedge clk);
      check(pins, pins_exp(n >= 24, v));
      check({m720, reduced_write_current_n}, media_exp(v[2], v[3], idx[2*v[1:0] +: 2]));
    end
    $display("drive pin test ended");
    test_done();
  end
  // Cut a hung run short.
  initial begin
    repeat (30000) @(posedge clk);
    n_fail++;
    test_done();
  end
endmodule
